// File: verilog/mia_regs.svh
// Register offsets, field positions, reset values and vector addresses of the interrupt arbiter
`ifndef MIA_REGS_SVH
`define MIA_REGS_SVH

`define MIA_ADDR_W         12
`define MIA_IOR_ADDR       12'h0C8
`define MIA_STATUS_ADDR    12'h0CC
`define MIA_PINCFG_ADDR    12'h0D0

`define MIA_IOR_SENSE_BIT  6
`define MIA_IOR_POL_BIT    5
`define MIA_IOR_GEN_BIT    4
`define MIA_IOR_RESET      8'h00
`define MIA_PINCFG_RESET   8'h00

`define MIA_V1_PINS        3
`define MIA_V2_PINS        4
`define MIA_V2_EN_LSB      4

`define MIA_VEC_W          12
`define MIA_VEC0_ADDR      12'hFFC
`define MIA_VEC1_ADDR      12'hFF6
`define MIA_VEC2_ADDR      12'hFF4
`define MIA_VEC3_ADDR      12'hFF2
`define MIA_VEC4_ADDR      12'hFF0

`endif

// File: verilog/mia_pkg.sv
// Types of the interrupt arbiter
`default_nettype none
package mia_pkg;

  // Bit 1: non-maskable routine running, bit 0: maskable routine running or suspended
  typedef enum logic [1:0] {
    mia_normal        = 2'b00,
    mia_maskable      = 2'b01,
    mia_nmi_over_mask = 2'b11,
    mia_nmi_over_norm = 2'b10
  } mia_service_type;

endpackage : mia_pkg
`default_nettype wire

// File: verilog/mia_interrupt_arbiter.sv
// Interrupt latching, arbitration, vector load and wake-up for a small 8-bit core
//
// Overview of operation
// - Four maskable sources and one non-maskable source, each with a fixed vector.
// - Maskable requests serviced only with global enable; events stay latched meanwhile.
// - On acceptance the program counter loads the winning source's vector address.
// - Several events share a vector; peripherals keep flags identifying the cause.
// - Reset overrides everything and aborts any running service routine.
// - Non-maskable request preempts maskable routines, never another non-maskable routine.
// - No maskable preemption; pending maskable requests granted vector 1 first, 4 last.
// - All sources wake from WAIT; only external and stop-capable ones from STOP.
// - Falling edge on non-maskable input requests vector 0 regardless of global enable.
// - Non-maskable request flip-flop cleared automatically when its routine begins.
// - Peripheral request needs active flag, global enable and its local enable.
// - Peripherals use vectors 3 and 4; flags stay set until software clears.
// - Port requests use vectors 1 and 2, need event and enable, wake from STOP.
// - Vector 1 edge or level sensing chosen by the sense select bit.
// - Vector 2 always edge sensing, direction chosen by the polarity bit.
// - Edge latch set by active edge, cleared at routine start; one pending kept.
// - Level mode stores nothing; line must be low when sampled at boundary.
// - Switching vector 2 to rising polarity with interrupt pins latches one request.
// - A vector 2 pin held at active level blocks edges on other pins.
// - Falling polarity: making a low pin an interrupt input latches a request.
// - Rising polarity: making a low interrupt pin plain input latches a request.
// - Sense select 0 is falling edge, 1 is low level.
// - Polarity bit 0 is falling edge, 1 is rising edge.
// - With global enable clear, non-maskable is serviced but wakes nothing.
// - Accepting a request inhibits maskable lines until return; non-maskable stays live only in maskable routines.
`include "mia_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module mia_interrupt_arbiter (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`MIA_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic      [31:0]              prdata,
  output logic                          pslverr,
  input  wire logic                     nmi_pin_n,
  input  wire logic [`MIA_V1_PINS-1:0]  port_a_pin,
  input  wire logic [`MIA_V2_PINS-1:0]  port_b_pin,
  input  wire logic                     timer_zero_flag,
  input  wire logic                     timer_irq_enable,
  input  wire logic                     adc_eoc_flag,
  input  wire logic                     adc_irq_enable,
  input  wire logic                     instr_boundary,
  input  wire logic                     return_from_irq_instr,
  input  wire logic                     core_in_wait,
  input  wire logic                     core_in_stop,
  output logic                          pc_load,
  output logic      [`MIA_VEC_W-1:0]    pc_vector,
  output logic                          in_nmi_service,
  output logic                          in_maskable_service,
  output logic                          wake_core
);

  localparam int PINS = 1 + `MIA_V1_PINS + `MIA_V2_PINS;

  logic [PINS-1:0]             sync_meta;
  logic [PINS-1:0]             sync_pins;
  logic                        nmi_prev;
  logic                        vector1_sense_select;
  logic                        vector2_edge_polarity;
  logic                        global_irq_enable;
  logic [`MIA_V1_PINS-1:0]     v1_pin_en;
  logic [`MIA_V2_PINS-1:0]     v2_pin_en;
  logic                        v1_active_prev;
  logic                        v2_active_prev;
  logic                        v2_pol_prev;
  logic                        v1_level_req;
  logic                        nmi_latch;
  logic                        v1_latch;
  logic                        v2_latch;
  mia_pkg::mia_service_type    state;
  mia_pkg::mia_service_type    next_state;

  // Synchronised pins, split by function
  logic                        nmi_sync_n;
  logic [`MIA_V1_PINS-1:0]     pa_sync;
  logic [`MIA_V2_PINS-1:0]     pb_sync;
  assign nmi_sync_n = sync_pins[PINS-1];
  assign pa_sync    = sync_pins[`MIA_V1_PINS+`MIA_V2_PINS-1:`MIA_V2_PINS];
  assign pb_sync    = sync_pins[`MIA_V2_PINS-1:0];

  // Two-stage synchroniser, all pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_meta <= '1;
      sync_pins <= '1;
    end else begin
      sync_meta <= {nmi_pin_n, port_a_pin, port_b_pin};
      sync_pins <= sync_meta;
    end
  end

  // APB access decode
  logic setup_phase;
  logic wr_access;
  logic wr_ior;
  logic wr_pincfg;
  assign setup_phase = psel & ~penable;
  assign wr_access   = psel & penable & pready & pwrite;
  assign wr_ior      = wr_access & (paddr == `MIA_IOR_ADDR);
  assign wr_pincfg   = wr_access & (paddr == `MIA_PINCFG_ADDR);

  // Answer in the first access cycle; ready is registered at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_phase;
      if (!setup_phase) begin
        pslverr <= 1'b0;
      end else if (paddr == `MIA_IOR_ADDR) begin
        pslverr <= 1'b0;
      end else if (paddr == `MIA_STATUS_ADDR) begin
        pslverr <= pwrite;
      end else if (paddr == `MIA_PINCFG_ADDR) begin
        pslverr <= 1'b0;
      end else begin
        pslverr <= 1'b1;
      end
    end
  end

  // Option register is write-only, so it reads back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      if (paddr == `MIA_STATUS_ADDR) begin
        prdata <= {24'h00_0000, wake_core, global_irq_enable, state, v1_level_req, v2_latch, v1_latch, nmi_latch};
      end else if (paddr == `MIA_PINCFG_ADDR) begin
        prdata <= {24'h00_0000, v2_pin_en, 1'b0, v1_pin_en};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Option register; reserved bits are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector1_sense_select  <= 1'(`MIA_IOR_RESET >> `MIA_IOR_SENSE_BIT);
      vector2_edge_polarity <= 1'(`MIA_IOR_RESET >> `MIA_IOR_POL_BIT);
      global_irq_enable     <= 1'(`MIA_IOR_RESET >> `MIA_IOR_GEN_BIT);
    end else if (wr_ior) begin
      vector1_sense_select  <= pwdata[`MIA_IOR_SENSE_BIT];
      vector2_edge_polarity <= pwdata[`MIA_IOR_POL_BIT];
      global_irq_enable     <= pwdata[`MIA_IOR_GEN_BIT];
    end
  end

  // Per-pin interrupt-input mode of the port pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v1_pin_en <= 3'(`MIA_PINCFG_RESET);
      v2_pin_en <= 4'(`MIA_PINCFG_RESET >> `MIA_V2_EN_LSB);
    end else if (wr_pincfg) begin
      v1_pin_en <= pwdata[`MIA_V1_PINS-1:0];
      v2_pin_en <= pwdata[`MIA_V2_EN_LSB+`MIA_V2_PINS-1:`MIA_V2_EN_LSB];
    end
  end

  // Shared lines: pins in plain mode sit inactive
  logic v1_active;
  logic v2_active;
  always_comb begin
    v1_active = ~&(pa_sync | ~v1_pin_en);
    // one pin held active keeps the shared line active
    if (vector2_edge_polarity) begin
      v2_active = |(pb_sync & v2_pin_en);
    end else begin
      v2_active = ~&(pb_sync | ~v2_pin_en);
    end
  end
  // level mode samples the pins, nothing stored
  assign v1_level_req = vector1_sense_select & v1_active;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_prev       <= 1'b1;
      v1_active_prev <= 1'b0;
      v2_active_prev <= 1'b0;
      v2_pol_prev    <= 1'(`MIA_IOR_RESET >> `MIA_IOR_POL_BIT);
    end else begin
      v2_pol_prev    <= vector2_edge_polarity;
      nmi_prev       <= nmi_sync_n;
      v1_active_prev <= v1_active;
      v2_active_prev <= v2_active;
    end
  end

  // Edge events, including the configuration artefacts of the vector 2 circuit
  logic nmi_fall;
  logic v1_edge;
  logic v2_edge;
  logic spur_polarity;
  logic spur_unconfig;
  logic [`MIA_V2_PINS-1:0] next_v2_en;
  assign next_v2_en = pwdata[`MIA_V2_EN_LSB+`MIA_V2_PINS-1:`MIA_V2_EN_LSB];
  assign nmi_fall = nmi_prev & ~nmi_sync_n;
  assign v1_edge  = ~vector1_sense_select & v1_active & ~v1_active_prev;
  // always edge, direction set by the polarity bit
  // A polarity flip is no edge; the spurious latch alone stands for it
  assign v2_edge  = v2_active & ~v2_active_prev & (vector2_edge_polarity == v2_pol_prev);
  // polarity to rising with interrupt pins
  assign spur_polarity = wr_ior & pwdata[`MIA_IOR_POL_BIT] & ~vector2_edge_polarity & |v2_pin_en;
  // low interrupt pin made plain under rising
  assign spur_unconfig = wr_pincfg & vector2_edge_polarity & |(v2_pin_en & ~next_v2_en & ~pb_sync);
  // the falling case arrives as a normal edge, since the line drops when the low pin joins it

  // Arbitration at instruction boundaries
  logic       maskable_ok;
  logic       v3_req;
  logic       v4_req;
  logic [4:0] grant;
  // flag and local enable; global enable is applied in maskable_ok
  assign v3_req = timer_zero_flag & timer_irq_enable;
  assign v4_req = adc_eoc_flag & adc_irq_enable;
  // maskable lines gated by enable and inhibit
  assign maskable_ok = global_irq_enable & (state == mia_pkg::mia_normal);

  always_comb begin
    grant = 5'h00;
    // boundary only; a return takes that cycle
    if (instr_boundary && !return_from_irq_instr) begin
      if (nmi_latch && !state[1]) begin
        grant = 5'h01;
      end else if (maskable_ok && (v1_latch || v1_level_req)) begin
        grant = 5'h02;
      end else if (maskable_ok && v2_latch) begin
        grant = 5'h04;
      // peripherals on vectors 3 and 4
      end else if (maskable_ok && v3_req) begin
        grant = 5'h08;
      end else if (maskable_ok && v4_req) begin
        grant = 5'h10;
      end
    end
  end

  // Request latches; a new event in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_latch <= 1'b0;
      v1_latch  <= 1'b0;
      v2_latch  <= 1'b0;
    end else begin
      nmi_latch <= nmi_fall | (nmi_latch & ~grant[0]);
      // one pending request per edge latch
      v1_latch  <= v1_edge | (v1_latch & ~grant[1] & ~vector1_sense_select);
      v2_latch  <= v2_edge | spur_polarity | spur_unconfig | (v2_latch & ~grant[2]);
    end
  end

  // Service level tracking
  always_comb begin
    next_state = state;
    case (state)
      mia_pkg::mia_normal: begin
        if (grant[0]) begin
          next_state = mia_pkg::mia_nmi_over_norm;
        end else if (|grant[4:1]) begin
          next_state = mia_pkg::mia_maskable;
        end
      end
      mia_pkg::mia_maskable: begin
        if (return_from_irq_instr) begin
          next_state = mia_pkg::mia_normal;
        end else if (grant[0]) begin
          next_state = mia_pkg::mia_nmi_over_mask;
        end
      end
      mia_pkg::mia_nmi_over_mask: begin
        if (return_from_irq_instr) begin
          next_state = mia_pkg::mia_maskable;
        end
      end
      mia_pkg::mia_nmi_over_norm: begin
        if (return_from_irq_instr) begin
          next_state = mia_pkg::mia_normal;
        end
      end
      default: begin
        next_state = mia_pkg::mia_normal;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state               <= mia_pkg::mia_normal;
      in_nmi_service      <= 1'b0;
      in_maskable_service <= 1'b0;
    end else begin
      state               <= next_state;
      in_nmi_service      <= next_state[1];
      in_maskable_service <= next_state[0];
    end
  end

  // vector address loaded with a one-cycle strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_load   <= 1'b0;
      pc_vector <= `MIA_VEC0_ADDR;
    end else begin
      pc_load <= |grant;
      if (grant[0]) begin
        pc_vector <= `MIA_VEC0_ADDR;
      end else if (grant[1]) begin
        pc_vector <= `MIA_VEC1_ADDR;
      end else if (grant[2]) begin
        pc_vector <= `MIA_VEC2_ADDR;
      end else if (grant[3]) begin
        pc_vector <= `MIA_VEC3_ADDR;
      end else if (grant[4]) begin
        pc_vector <= `MIA_VEC4_ADDR;
      end
    end
  end

  // Wake-up; the converter cannot run in STOP, so it is left out there
  logic wake_wait;
  logic wake_stop;
  assign wake_wait = core_in_wait & (nmi_latch | v1_latch | v1_level_req | v2_latch | v3_req | v4_req);
  assign wake_stop = core_in_stop & (nmi_latch | v1_latch | v1_level_req | v2_latch | v3_req);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_core <= 1'b0;
    end else begin
      // nothing wakes with global enable clear
      wake_core <= global_irq_enable & (wake_wait | wake_stop);
    end
  end

endmodule : mia_interrupt_arbiter
`default_nettype wire

// File: dv/mia_arbiter_props.sv
// Concurrent checks on the interrupt arbiter ports
`include "mia_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module mia_arbiter_props (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`MIA_ADDR_W-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic                   pready,
  input wire logic                   instr_boundary,
  input wire logic                   return_from_irq_instr,
  input wire logic                   core_in_wait,
  input wire logic                   core_in_stop,
  input wire logic                   pc_load,
  input wire logic [`MIA_VEC_W-1:0]  pc_vector,
  input wire logic                   in_nmi_service,
  input wire logic                   in_maskable_service,
  input wire logic                   wake_core
);
  logic gen_on;

  // Shadow of the global enable, followed from completed writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gen_on <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == `MIA_IOR_ADDR) gen_on <= pwdata[`MIA_IOR_GEN_BIT];
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_mask_ret;
    return_from_irq_instr && in_maskable_service && !in_nmi_service;
  endsequence

  a_nmi_vector: assert property ($rose(in_nmi_service) |-> pc_load && pc_vector == `MIA_VEC0_ADDR)
    else $error("nmi entry without vector 0 load");
  a_mask_vector: assert property ($rose(in_maskable_service) |-> pc_load && !in_nmi_service
    && pc_vector inside {`MIA_VEC1_ADDR, `MIA_VEC2_ADDR, `MIA_VEC3_ADDR, `MIA_VEC4_ADDR})
    else $error("maskable entry with a wrong vector");
  a_mask_preempt: assert property (pc_load && $past(in_maskable_service) |-> pc_vector == `MIA_VEC0_ADDR)
    else $error("maskable routine preempted by a maskable request");
  a_nmi_no_nest: assert property ($past(in_nmi_service) |-> !pc_load)
    else $error("grant during a non-maskable routine");
  a_grant_boundary: assert property (pc_load |-> $past(instr_boundary) && !$past(return_from_irq_instr))
    else $error("grant outside an instruction boundary");
  a_grant_gen: assert property (pc_load && pc_vector != `MIA_VEC0_ADDR |-> $past(gen_on))
    else $error("maskable grant with global enable clear");
  a_ret_release: assert property (s_mask_ret |=> !in_maskable_service && !pc_load)
    else $error("return did not release the maskable routine");
  a_wake_gen: assert property (wake_core |-> $past(gen_on) && $past(core_in_wait || core_in_stop))
    else $error("wake request without enable or low power mode");
endmodule : mia_arbiter_props

bind mia_interrupt_arbiter mia_arbiter_props i_mia_arbiter_props (.*);
`default_nettype wire

// File: dv/mia_core_model.sv
// Core side model: instruction boundaries and return pulses
`timescale 1ns/1ps
`default_nettype none

module mia_core_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ret_go,
  output logic      instr_boundary,
  output logic      return_from_irq_instr
);
  logic [1:0] cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 2'h0;
    else cnt <= cnt + 2'h1;
  end
  assign instr_boundary = (cnt == 2'h3);

  // return instruction one cycle after the bench asks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) return_from_irq_instr <= 1'b0;
    else return_from_irq_instr <= ret_go;
  end
endmodule : mia_core_model
`default_nettype wire

// File: dv/mia_interrupt_arbiter_tb.sv
// Self-checking bench of the interrupt arbiter
`include "mia_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module mia_interrupt_arbiter_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0, pc_vector;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        nmi_pin_n = 1, t_flag = 0, t_en = 0, a_flag = 0, a_en = 0, wait_m = 0, stop_m = 0;
  logic [2:0]  pa = 3'h7;
  logic [3:0]  pb = 4'hF;
  logic        bnd, ret, ret_go = 0, pc_load, in_nmi, in_mask, wake, err;
  int          errors = 0, cmp_count = 0, cyc = 0;

  initial forever #4 pclk = ~pclk;

  mia_interrupt_arbiter i_mia_interrupt_arbiter (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .nmi_pin_n(nmi_pin_n), .port_a_pin(pa), .port_b_pin(pb),
    .timer_zero_flag(t_flag), .timer_irq_enable(t_en), .adc_eoc_flag(a_flag), .adc_irq_enable(a_en),
    .instr_boundary(bnd), .return_from_irq_instr(ret), .core_in_wait(wait_m), .core_in_stop(stop_m),
    .pc_load(pc_load), .pc_vector(pc_vector), .in_nmi_service(in_nmi),
    .in_maskable_service(in_mask), .wake_core(wake));

  mia_core_model i_mia_core_model (.pclk(pclk), .presetn(presetn), .ret_go(ret_go),
    .instr_boundary(bnd), .return_from_irq_instr(ret));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  task automatic wait_load(input logic [11:0] v);
    for (int n = 0; n < 60; n++) begin
      @(posedge pclk);
      if (pc_load === 1'b1) break;
    end
    chk("pc_load", pc_load, 1);
    chk("pc_vector", pc_vector, v);
  endtask : wait_load

  task automatic no_load(input int n);
    int hits;
    hits = 0;
    repeat (n) begin
      @(posedge pclk);
      if (pc_load !== 1'b0) hits++;
    end
    chk("idle pc_load", hits, 0);
  endtask : no_load

  task automatic do_ret;
    @(posedge pclk); ret_go <= 1;
    @(posedge pclk); ret_go <= 0;
  endtask : do_ret

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // Ceiling well above the few hundred cycles of the run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    apb(0, `MIA_STATUS_ADDR, 0); chk("status reset", rd, 0);
    apb(0, `MIA_IOR_ADDR, 0); chk("ior reads zero", rd, 0);
    apb(0, 12'h0F0, 0); chk("unmapped err", err, 1);
    apb(1, `MIA_STATUS_ADDR, 32'hFF); chk("status write err", err, 1);
    $display("test reset done");
    wait_m <= 1;
    nmi_pin_n <= 0;
    wait_load(`MIA_VEC0_ADDR);
    chk("nmi wake", wake, 0);
    nmi_pin_n <= 1; wait_m <= 0;
    do_ret; repeat (2) @(posedge pclk);
    chk("nmi end", in_nmi, 0);
    $display("test nmi done");
    apb(1, `MIA_PINCFG_ADDR, 32'h11);
    pa[0] <= 0; repeat (3) @(posedge pclk); pa[0] <= 1;
    t_flag <= 1; t_en <= 1;
    no_load(20);
    apb(0, `MIA_STATUS_ADDR, 0); chk("v1 held", rd[1], 1);
    apb(1, `MIA_IOR_ADDR, 32'h10);
    wait_load(`MIA_VEC1_ADDR);
    do_ret;
    wait_load(`MIA_VEC3_ADDR);
    t_flag <= 0; do_ret;
    a_flag <= 1; a_en <= 1;
    wait_load(`MIA_VEC4_ADDR);
    stop_m <= 1; repeat (3) @(posedge pclk);
    chk("stop wake v4", wake, 0);
    stop_m <= 0; wait_m <= 1; repeat (3) @(posedge pclk);
    chk("wait wake v4", wake, 1);
    wait_m <= 0; nmi_pin_n <= 0;
    wait_load(`MIA_VEC0_ADDR);
    chk("mask kept", in_mask, 1);
    nmi_pin_n <= 1; do_ret; a_flag <= 0;
    repeat (2) @(posedge pclk); do_ret;
    no_load(20);
    $display("test priority done");
    apb(1, `MIA_IOR_ADDR, 32'h30);
    wait_load(`MIA_VEC2_ADDR);
    do_ret;
    $display("test polarity done");
    apb(1, `MIA_IOR_ADDR, 32'h50);
    pa[0] <= 0;
    wait_load(`MIA_VEC1_ADDR);
    do_ret;
    wait_load(`MIA_VEC1_ADDR);
    pa[0] <= 1; do_ret;
    no_load(20);
    apb(0, `MIA_STATUS_ADDR, 0); chk("level stored", {rd[3], rd[1]}, 0);
    $display("test level done");
    pa[0] <= 0;
    wait_load(`MIA_VEC1_ADDR);
    presetn <= 0; repeat (2) @(posedge pclk);
    chk("reset abort", {in_mask, in_nmi}, 0);
    chk("reset vector", pc_vector, `MIA_VEC0_ADDR);
    pa[0] <= 1; presetn <= 1;
    $display("test reset abort done");
    close_out();
  end
endmodule : mia_interrupt_arbiter_tb
`default_nettype wire
